// [src/rst_seq_defines.svh]
// Offsets, reset values and timing counts of the reset sequencer.
// Assumes the core clock is the oscillator clock at the rate given below.
`ifndef RST_SEQ_DEFINES_SVH
`define RST_SEQ_DEFINES_SVH

`define RST_SEQ_CLK_MHZ 100
`define RST_SEQ_PIN_LOW_MIN 8
`define RST_SEQ_STARTUP_MS 64
`define RST_SEQ_STARTUP_EXTRA 7
`define RST_SEQ_STARTUP_CYCLES \
  (`RST_SEQ_STARTUP_MS * 1000 * `RST_SEQ_CLK_MHZ + `RST_SEQ_STARTUP_EXTRA)
`define RST_SEQ_PF_FILTER_NS 100
`define RST_SEQ_PF_FILTER_CYCLES \
  ((`RST_SEQ_PF_FILTER_NS * `RST_SEQ_CLK_MHZ + 999) / 1000)
`define RST_SEQ_PF_LEVELS 4
`define RST_SEQ_VEC_LO_ADDR 16'hFFFE
`define RST_SEQ_VEC_HI_ADDR 16'hFFFF
`define RST_SEQ_ADDR_IDLE 16'h0000
`define RST_SEQ_RAM_PAGE_RST 8'h00
`define RST_SEQ_PF_CTRL_RST 8'h00
`define RST_SEQ_PF_DIS_BIT 0
`define RST_SEQ_PF_ACT_BIT 1

`endif

// [src/rst_seq_pkg.sv]
// Types shared by the reset sequencer and its self-checking bench.
// Assumes nothing beyond a SystemVerilog elaborator.
package rst_seq_pkg;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_DELAY,
    ST_VEC_LO,
    ST_VEC_HI,
    ST_VEC_END,
    ST_RUN
  } seq_state_type;

  // Core control state that every reset puts back to its defaults.
  typedef struct packed {
    logic [7:0] ram_page_register;
    logic direct_page_flag;
    logic main_clock_sel;
  } core_ctrl_type;

  // Which source caused the most recent reset.
  typedef struct packed {
    logic pin;
    logic watchdog;
    logic power_fail;
  } reset_cause_type;

endpackage

// [src/supply_fail_filter.sv]
// Power-fail filter: picks one supply comparator and demands a held level.
// Assumes the comparator outputs are asynchronous and the level select
// comes from a static nonvolatile configuration word.
`timescale 1ns/100ps
`include "rst_seq_defines.svh"

module supply_fail_filter #(
  parameter int LEVELS = `RST_SEQ_PF_LEVELS,
  parameter int FILTER_CYCLES = `RST_SEQ_PF_FILTER_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Control.
  input wire logic enable,
  input wire logic [1:0] level_sel,
  // Comparators, one per threshold, high while the supply is below it.
  input wire logic [LEVELS-1:0] supply_below,
  // Filtered result.
  output logic fail
);

  localparam int CW = $clog2(FILTER_CYCLES + 1);

  logic [LEVELS-1:0] meta_r;
  logic [LEVELS-1:0] sync_r;
  logic [CW-1:0] cnt_r;
  logic below_sel;

  genvar i;
  generate
    for (i = 0; i < LEVELS; i++) begin : g_sync
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
        end else if (clk_en) begin
          meta_r[i] <= supply_below[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  // A 3.0 V level on a 3 V supply never clears, so fail stays high.
  assign below_sel = sync_r[level_sel];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
      fail <= 1'b0;
    end else if (clk_en) begin
      if (!enable || !below_sel) begin
        cnt_r <= '0;
        fail <= 1'b0;
      end else if (cnt_r == CW'(FILTER_CYCLES - 1)) begin
        fail <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule

// [src/reset_and_power_fail_sequencer.sv]
// What this block does
// - A reset pin low for at least eight clock periods is a valid reset.
// - After release the core stays halted 64 ms plus seven periods.
// - The program counter is then loaded from the vector at FFFE/FFFF.
// - No reset touches the contents of internal data RAM.
// - Reset clears RAM page and direct-page flag, selects the main clock.
// - Pin and watchdog resets give the same initialisation.
// - Supply at or below threshold for 100 ns resets or freezes the core.
// - The power-fail disable bit turns detection off entirely.
// - Two configuration bits choose the power-fail threshold.
// - A 3.0 V threshold on a 3 V supply keeps the core frozen for good.
// - Watchdog expiry with reset select set runs full reset processing.
//
// Reset and power-fail sequencer for a small 8-bit controller.
// Assumes the vector memory answers one cycle after vector_rd and addr.
`timescale 1ns/100ps
`include "rst_seq_defines.svh"

module reset_and_power_fail_sequencer #(
  parameter int STARTUP_CYCLES = `RST_SEQ_STARTUP_CYCLES,
  parameter int PIN_LOW_MIN = `RST_SEQ_PIN_LOW_MIN
) (
  // Clock, power-on reset and clock enable.
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // External reset pin, asynchronous.
  input wire logic reset_pin_n,
  // Watchdog, same clock.
  input wire logic watchdog_expire,
  input wire logic watchdog_reset_select,
  // Power-fail configuration word and comparators.
  input wire logic power_fail_level_select_lo,
  input wire logic power_fail_level_select_hi,
  input wire logic [`RST_SEQ_PF_LEVELS-1:0] supply_below,
  // Power-fail control register write.
  input wire logic pf_ctrl_wr,
  input wire logic [7:0] pf_ctrl_wdata,
  // Core control write.
  input wire logic core_ctrl_wr,
  input wire rst_seq_pkg::core_ctrl_type core_ctrl_wdata,
  // Vector memory.
  output logic vector_rd,
  output logic [15:0] vector_addr,
  input wire logic [7:0] vector_rdata,
  // Core side.
  output logic system_reset,
  output logic core_run,
  output logic core_freeze,
  output logic pc_load,
  output logic [15:0] program_counter,
  output rst_seq_pkg::core_ctrl_type core_ctrl,
  output logic [7:0] power_fail_control_register,
  output logic watchdog_irq,
  output rst_seq_pkg::reset_cause_type reset_cause
);

  localparam int DW = $clog2(STARTUP_CYCLES + 1);
  localparam int PW = $clog2(PIN_LOW_MIN + 1);
  localparam int HW = DW + 2;

  rst_seq_pkg::seq_state_type state_r;
  rst_seq_pkg::seq_state_type state_nxt;
  logic pin_meta_r;
  logic pin_sync_r;
  logic [PW-1:0] low_cnt_r;
  logic pin_reset_r;
  logic [DW-1:0] dly_cnt_r;
  logic [7:0] pc_lo_r;
  logic pf_fail;
  logic pf_enable;
  logic pf_act_reset;
  logic wdt_reset;
  logic pf_reset;
  logic reset_req;
  logic [HW-1:0] since_hold_r;

  assign pf_enable = !power_fail_control_register[`RST_SEQ_PF_DIS_BIT];
  assign pf_act_reset = power_fail_control_register[`RST_SEQ_PF_ACT_BIT];
  assign wdt_reset = watchdog_expire && watchdog_reset_select;
  assign pf_reset = pf_fail && pf_enable && pf_act_reset;
  // Every source funnels into one request.
  assign reset_req = pin_reset_r || wdt_reset || pf_reset;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
    end else if (clk_en) begin
      pin_meta_r <= reset_pin_n;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Minimum low time.
  // A pulse shorter than the minimum only restarts the count.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_cnt_r <= '0;
      pin_reset_r <= 1'b0;
    end else if (clk_en) begin
      if (pin_sync_r) begin
        low_cnt_r <= '0;
        pin_reset_r <= 1'b0;
      end else if (low_cnt_r == PW'(PIN_LOW_MIN - 1)) begin
        pin_reset_r <= 1'b1;
      end else begin
        low_cnt_r <= low_cnt_r + 1'b1;
      end
    end
  end

  supply_fail_filter #(
    .LEVELS(`RST_SEQ_PF_LEVELS),
    .FILTER_CYCLES(`RST_SEQ_PF_FILTER_CYCLES)
  ) u_filter (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .enable(pf_enable),
    .level_sel({power_fail_level_select_hi, power_fail_level_select_lo}),
    .supply_below(supply_below),
    .fail(pf_fail)
  );

  // Sequence from hold through start-up delay to the vector fetch.
  always_comb begin
    state_nxt = state_r;
    if (reset_req) begin
      state_nxt = rst_seq_pkg::ST_HOLD;
    end else begin
      unique case (state_r)
        rst_seq_pkg::ST_HOLD: state_nxt = rst_seq_pkg::ST_DELAY;
        rst_seq_pkg::ST_DELAY: begin
          if (dly_cnt_r == DW'(STARTUP_CYCLES - 1)) begin
            state_nxt = rst_seq_pkg::ST_VEC_LO;
          end
        end
        rst_seq_pkg::ST_VEC_LO: state_nxt = rst_seq_pkg::ST_VEC_HI;
        rst_seq_pkg::ST_VEC_HI: state_nxt = rst_seq_pkg::ST_VEC_END;
        rst_seq_pkg::ST_VEC_END: state_nxt = rst_seq_pkg::ST_RUN;
        rst_seq_pkg::ST_RUN: state_nxt = rst_seq_pkg::ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= rst_seq_pkg::ST_HOLD;
      system_reset <= 1'b1;
      core_run <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      system_reset <= (state_nxt == rst_seq_pkg::ST_HOLD);
      core_run <= (state_nxt == rst_seq_pkg::ST_RUN);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dly_cnt_r <= '0;
    end else if (clk_en) begin
      if (state_r != rst_seq_pkg::ST_DELAY) begin
        dly_cnt_r <= '0;
      end else begin
        dly_cnt_r <= dly_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vector_rd <= 1'b0;
      vector_addr <= `RST_SEQ_ADDR_IDLE;
      pc_lo_r <= 8'h00;
      program_counter <= `RST_SEQ_ADDR_IDLE;
      pc_load <= 1'b0;
    end else if (clk_en) begin
      pc_load <= 1'b0;
      vector_rd <= 1'b0;
      vector_addr <= `RST_SEQ_ADDR_IDLE;
      if (state_nxt == rst_seq_pkg::ST_VEC_LO) begin
        vector_rd <= 1'b1;
        vector_addr <= `RST_SEQ_VEC_LO_ADDR;
      end else if (state_nxt == rst_seq_pkg::ST_VEC_HI) begin
        vector_rd <= 1'b1;
        vector_addr <= `RST_SEQ_VEC_HI_ADDR;
      end
      if (state_r == rst_seq_pkg::ST_VEC_HI) begin
        pc_lo_r <= vector_rdata;
      end
      if (state_r == rst_seq_pkg::ST_VEC_END && !reset_req) begin
        program_counter <= {vector_rdata, pc_lo_r};
        pc_load <= 1'b1;
      end
    end
  end

  // Control state back to defaults while held in reset.
  // Data RAM has no path from here, so its contents survive.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_ctrl.ram_page_register <= `RST_SEQ_RAM_PAGE_RST;
      core_ctrl.direct_page_flag <= 1'b0;
      core_ctrl.main_clock_sel <= 1'b1;
      power_fail_control_register <= `RST_SEQ_PF_CTRL_RST;
    end else if (clk_en) begin
      if (state_nxt == rst_seq_pkg::ST_HOLD) begin
        core_ctrl.ram_page_register <= `RST_SEQ_RAM_PAGE_RST;
        core_ctrl.direct_page_flag <= 1'b0;
        core_ctrl.main_clock_sel <= 1'b1;
        // A power-fail reset keeps the action bit until release, or the
        // reset would fall back to a freeze while the supply is still low.
        if (!pf_reset) begin
          power_fail_control_register <= `RST_SEQ_PF_CTRL_RST;
        end
      end else if (state_r == rst_seq_pkg::ST_HOLD) begin
        power_fail_control_register <= `RST_SEQ_PF_CTRL_RST;
      end else if (core_run) begin
        if (core_ctrl_wr) begin
          core_ctrl <= core_ctrl_wdata;
        end
        if (pf_ctrl_wr) begin
          power_fail_control_register <= pf_ctrl_wdata;
        end
      end
    end
  end

  // Freeze follows the filtered fail level, so it lifts on recovery.
  // Without reset select the expiry is only an interrupt.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_freeze <= 1'b0;
      watchdog_irq <= 1'b0;
    end else if (clk_en) begin
      core_freeze <= pf_fail && pf_enable && !pf_act_reset;
      watchdog_irq <= watchdog_expire && !watchdog_reset_select;
    end
  end

  // Cause of the last reset, recaptured on every cycle that reset_req is high.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reset_cause <= '0;
    end else if (clk_en && reset_req) begin
      reset_cause.pin <= pin_reset_r;
      reset_cause.watchdog <= wdt_reset;
      reset_cause.power_fail <= pf_reset;
    end
  end

  // Cycles since hold was left, read only by the checks below.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      since_hold_r <= '0;
    end else if (clk_en) begin
      if (state_r == rst_seq_pkg::ST_HOLD) begin
        since_hold_r <= '0;
      end else if (!core_run) begin
        since_hold_r <= since_hold_r + 1'b1;
      end
    end
  end

  a_pin_min_low: assert property (
    @(posedge clk iff clk_en) disable iff (reset)
    (!pin_sync_r) [*8] |=> pin_reset_r)
    else $error("Pin held low eight cycles gave no reset.");

  a_pin_glitch_ignored: assert property (
    @(posedge clk iff clk_en) disable iff (reset)
    $rose(pin_reset_r) |-> $past(!pin_sync_r, 8) && $past(!pin_sync_r, 1))
    else $error("Pin reset after a low pulse shorter than eight cycles.");

  a_startup_delay: assert property (
    @(posedge clk iff clk_en) disable iff (reset)
    $rose(core_run) |-> since_hold_r == HW'(STARTUP_CYCLES + 3))
    else $error("Start-up delay before execution has the wrong length.");

  a_vector_load: assert property (
    @(posedge clk iff clk_en) disable iff (reset)
    pc_load |-> program_counter[15:8] == $past(vector_rdata, 1)
      && program_counter[7:0] == $past(vector_rdata, 2)
      && $past(vector_addr, 3) == `RST_SEQ_VEC_LO_ADDR
      && $past(vector_addr, 2) == `RST_SEQ_VEC_HI_ADDR)
    else $error("Program counter not loaded from the reset vector.");

  a_ctrl_defaults: assert property (
    @(posedge clk iff clk_en) disable iff (reset)
    system_reset |-> core_ctrl.ram_page_register == `RST_SEQ_RAM_PAGE_RST
      && !core_ctrl.direct_page_flag && core_ctrl.main_clock_sel
      && !core_run)
    else $error("Control state not at defaults during reset.");

  a_wdt_reset: assert property (
    @(posedge clk iff clk_en) disable iff (reset)
    watchdog_expire && watchdog_reset_select
      |=> system_reset && !watchdog_irq ##1 !core_run)
    else $error("Watchdog expiry with reset select gave no reset.");

  a_pf_disabled: assert property (
    @(posedge clk iff clk_en) disable iff (reset)
    !pf_enable && $past(!pf_enable) |-> !core_freeze && !pf_reset)
    else $error("Disabled detector still froze or reset the core.");

  a_pf_freeze: assert property (
    @(posedge clk iff clk_en) disable iff (reset)
    pf_fail && pf_enable && !pf_act_reset
      |=> core_freeze && (state_r != rst_seq_pkg::ST_HOLD || $past(reset_req)))
    else $error("Fail in freeze mode did not freeze the core.");

endmodule

// [verif/reset_side_model.sv]
// Far-side model: the external reset circuit and the vector memory.
// Assumes the sequencer clock and a bench that requests pin pulses.
`timescale 1ns/100ps

module reset_side_model (
  // Clock.
  input wire logic clk,
  // Pin pulse request, length in clock cycles.
  input wire logic pulse_go,
  input wire logic [7:0] pulse_len,
  output logic reset_pin_n,
  // Vector memory.
  input wire logic [15:0] vector,
  input wire logic vector_rd,
  input wire logic [15:0] vector_addr,
  output logic [7:0] vector_rdata
);
  logic [7:0] low_cnt_r = 8'h00;

  initial vector_rdata = 8'h5A;

  always @(posedge clk) begin
    if (pulse_go) begin
      low_cnt_r <= pulse_len;
    end else if (low_cnt_r != 8'h00) begin
      low_cnt_r <= low_cnt_r - 8'h01;
    end
  end
  assign reset_pin_n = (low_cnt_r == 8'h00);

  // vector bytes
  // Unread cycles flip the data so a late or missed read cannot pass.
  always @(posedge clk) begin
    if (vector_rd && vector_addr == 16'hFFFE) begin
      vector_rdata <= vector[7:0];
    end else if (vector_rd && vector_addr == 16'hFFFF) begin
      vector_rdata <= vector[15:8];
    end else begin
      vector_rdata <= ~vector_rdata;
    end
  end
endmodule

// [verif/reset_and_power_fail_sequencer_bench.sv]
// Self-checking bench for the reset and power-fail sequencer.
// Assumes the far-side model and a shortened start-up count.
`timescale 1ns/100ps

module reset_and_power_fail_sequencer_bench;
  localparam int STARTUP = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic reset_pin_n, watchdog_expire, watchdog_reset_select;
  logic lvl_lo, lvl_hi, pf_ctrl_wr, core_ctrl_wr, pulse_go;
  logic vector_rd, system_reset, core_run, core_freeze, pc_load;
  logic watchdog_irq;
  logic [3:0] supply_below;
  logic [7:0] pf_ctrl_wdata, vector_rdata, pf_reg, pulse_len;
  logic [15:0] vector_addr, program_counter, vector;
  rst_seq_pkg::core_ctrl_type core_ctrl_wdata, core_ctrl;
  rst_seq_pkg::reset_cause_type reset_cause;
  int miscompares = 0;
  int tests_run = 0;
  int n;
  int run_wait = 0;
  logic seen;

  always #5 clk = ~clk;

  // Cycles from the fall of system_reset until the core runs.
  always @(posedge clk) begin
    if (system_reset) begin
      run_wait <= 0;
    end else if (!core_run) begin
      run_wait <= run_wait + 1;
    end
  end

  reset_and_power_fail_sequencer #(.STARTUP_CYCLES(STARTUP),
    .PIN_LOW_MIN(8)) u_reset_and_power_fail_sequencer (
    .clk(clk), .reset(reset), .clk_en(clk_en),
    .reset_pin_n(reset_pin_n), .watchdog_expire(watchdog_expire),
    .watchdog_reset_select(watchdog_reset_select),
    .power_fail_level_select_lo(lvl_lo),
    .power_fail_level_select_hi(lvl_hi), .supply_below(supply_below),
    .pf_ctrl_wr(pf_ctrl_wr), .pf_ctrl_wdata(pf_ctrl_wdata),
    .core_ctrl_wr(core_ctrl_wr), .core_ctrl_wdata(core_ctrl_wdata),
    .vector_rd(vector_rd), .vector_addr(vector_addr),
    .vector_rdata(vector_rdata), .system_reset(system_reset),
    .core_run(core_run), .core_freeze(core_freeze), .pc_load(pc_load),
    .program_counter(program_counter), .core_ctrl(core_ctrl),
    .power_fail_control_register(pf_reg), .watchdog_irq(watchdog_irq),
    .reset_cause(reset_cause));

  reset_side_model u_reset_side_model (
    .clk(clk), .pulse_go(pulse_go), .pulse_len(pulse_len),
    .reset_pin_n(reset_pin_n), .vector(vector), .vector_rd(vector_rd),
    .vector_addr(vector_addr), .vector_rdata(vector_rdata));

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic pulse(input int len);
    pulse_len = 8'(len);
    pulse_go = 1'b1;
    step(1);
    pulse_go = 1'b0;
  endtask

  task automatic pf_write(input logic [7:0] v);
    pf_ctrl_wdata = v;
    pf_ctrl_wr = 1'b1;
    step(1);
    pf_ctrl_wr = 1'b0;
    step(1);
  endtask

  // Waits for release, then times the start-up and the vector fetch.
  task automatic boot();
    vector = 16'($urandom());
    n = 0;
    while (system_reset !== 1'b0 && n < 100) begin
      step(1);
      n++;
    end
    n = 0;
    while (core_run !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    // The delay is followed by three cycles of vector fetch.
    check("startup cycles", 16'(STARTUP + 3), 16'(run_wait));
    check("pc load", 16'h0001, {15'h0000, pc_load});
    check("program counter", vector, program_counter);
  endtask

  function automatic logic [15:0] ctrl_default();
    return 16'h0001;
  endfunction

  initial begin
    #500000;
    miscompares++;
    end_of_test();
  end

  initial begin
    {watchdog_expire, watchdog_reset_select, lvl_lo, lvl_hi} = 4'h0;
    {pf_ctrl_wr, core_ctrl_wr, pulse_go} = 3'h0;
    supply_below = 4'h0;
    pf_ctrl_wdata = 8'h00;
    pulse_len = 8'h00;
    core_ctrl_wdata = '0;
    vector = 16'h0000;
    void'($urandom(68786));
    repeat (20) @(posedge clk);
    check("ctrl at reset", ctrl_default(), 16'(core_ctrl));
    check("pf reg at reset", 16'h0000, 16'(pf_reg));
    #1;
    reset = 1'b0;
    boot();
    // Glitches of one to seven cycles must be ignored.
    seen = 1'b0;
    for (int i = 1; i < 8; i++) begin
      pulse(i);
      repeat (20) begin
        step(1);
        seen = seen | system_reset;
      end
    end
    check("glitch reset", 16'h0000, {15'h0000, seen});
    pulse(8);
    n = 0;
    while (system_reset !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    check("pin reset", 16'h0001, {15'h0000, system_reset});
    check("pin cause", 16'h0001, {15'h0000, reset_cause.pin});
    // A second pin reset in mid start-up restarts the delay.
    while (system_reset !== 1'b0 && n < 60) begin
      step(1);
      n++;
    end
    step(5);
    pulse(8 + int'($urandom_range(12)));
    step(12);
    boot();
    // Watchdog: interrupt first, then reset.
    core_ctrl_wdata = {8'($urandom()), 1'b1, 1'b0};
    core_ctrl_wr = 1'b1;
    step(1);
    core_ctrl_wr = 1'b0;
    pf_write(8'h02);
    check("ctrl write", 16'(core_ctrl_wdata), 16'(core_ctrl));
    for (int s = 0; s < 2; s++) begin
      watchdog_reset_select = s[0];
      watchdog_expire = 1'b1;
      step(1);
      check("wd reset", 16'(s), {15'h0000, system_reset});
      check("wd irq", 16'(1 - s), {15'h0000, watchdog_irq});
      watchdog_expire = 1'b0;
      step(1);
    end
    step(2);
    check("wd cause", 16'h0001, {15'h0000, reset_cause.watchdog});
    check("ctrl after wd", ctrl_default(), 16'(core_ctrl));
    check("pf reg after wd", 16'h0000, 16'(pf_reg));
    boot();
    // Every threshold select, freeze action.
    for (int lvl = 0; lvl < 4; lvl++) begin
      {lvl_hi, lvl_lo} = 2'(lvl);
      supply_below = ~(4'h1 << lvl);
      step(30);
      check("unselected level", 16'h0000, {15'h0000, core_freeze});
      supply_below = 4'hF;
      step(20);
      check("freeze", 16'h0001, {15'h0000, core_freeze});
      step(50);
      check("held freeze", 16'h0001, {15'h0000, core_freeze});
      supply_below = 4'h0;
      step(10);
      check("resume", 16'h0000, {15'h0000, core_freeze});
    end
    pf_write(8'h02);
    supply_below = 4'hF;
    step(20);
    check("pf reset", 16'h0001, {15'h0000, system_reset});
    check("pf cause", 16'h0001, {15'h0000, reset_cause.power_fail});
    supply_below = 4'h0;
    boot();
    pf_write(8'h01);
    supply_below = 4'hF;
    step(30);
    check("disabled", 16'h0000, {14'h0, core_freeze, system_reset});
    supply_below = 4'h0;
    step(5);
    end_of_test();
  end
endmodule
